/* host_bus_sequencer.sv */
// Purpose: Host bus T-state sequencer with pointer shadow copy
// Assumes: Host pins asynchronous; code bus and memory ready on sys_clk
// Notes: Host and memory handshake pins are active low; refresh and FIFO request/grant are active high
`timescale 1ns/10ps
module host_bus_sequencer #(
  parameter int ptr_w = host_seq_pkg::ptr_w
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Host handshake pins
  input wire logic host_request_n,
  input wire logic reg_select_n,
  input wire logic mem_select_n,
  input wire logic addr_valid_strobe_n,
  output logic bus_grant_n,
  output logic host_ready_n,
  // Shared buses
  input wire logic write_enable_n_in,
  input wire logic [3:0] byte_enable_n_in,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic [3:0] byte_enable_n_out,
  output logic write_enable_n_out,
  output logic bus_drive_en,
  // Memory handshake
  output logic memory_request_n,
  input wire logic memory_ready_n,
  // Register file side
  input wire logic [15:0] reg_read_data,
  output logic [15:0] reg_write_data,
  output logic reg_write_strobe,
  // Display code bus and other requesters
  input wire logic [3:0] display_code_bus,
  input wire logic refresh_pending,
  input wire logic fifo_pending,
  output logic refresh_grant,
  output logic fifo_grant,
  // Statistical decoder pointer
  input wire logic decoder_load,
  input wire logic [ptr_w-1:0] decoder_load_value,
  input wire logic decoder_read,
  output logic [ptr_w-1:0] decoder_ptr,
  // Shadow and working pointers
  input wire host_seq_pkg::shadow_set_t shadow,
  output host_seq_pkg::working_set_t working,
  output logic field_is_odd
);

  typedef enum logic [3:0] {
    st_idle,
    st_grant_deadband,
    st_wait_addr_valid,
    st_mem_request,
    st_mem_wait,
    st_first_output,
    st_wait_complete,
    st_release,
    st_shadow,
    st_transfer,
    st_other
  } state_t;

  state_t state;
  host_seq_pkg::cycle_type_t cyc;
  logic req_s1, req_s2, alen_s1, alen_s2;
  logic reg_sel_s, mem_sel_s, we_s, be0_s;
  logic [1:0] req_hold;
  logic shadow_pending, shadow_from_line, shadow_even;
  logic xfer_pending;
  logic [1:0] xfer_sel;
  logic [1:0] shadow_cnt;
  logic [3:0] code_prev;
  logic code_new;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      alen_s1 <= 1'b0;
      alen_s2 <= 1'b0;
      reg_sel_s <= 1'b0;
      mem_sel_s <= 1'b0;
      we_s <= 1'b0;
      be0_s <= 1'b0;
    end else begin
      req_s1 <= ~host_request_n;
      req_s2 <= req_s1;
      alen_s1 <= ~addr_valid_strobe_n;
      alen_s2 <= alen_s1;
      reg_sel_s <= ~reg_select_n;
      mem_sel_s <= ~mem_select_n;
      we_s <= ~write_enable_n_in;
      be0_s <= ~byte_enable_n_in[0];
    end
  end

  function automatic host_seq_pkg::cycle_type_t decode_cycle(
      input logic rsel, input logic msel);
    unique case ({rsel, msel})
      2'b00: decode_cycle = host_seq_pkg::cyc_external;
      2'b10: decode_cycle = host_seq_pkg::cyc_register;
      2'b01: decode_cycle = host_seq_pkg::cyc_memory;
      default: decode_cycle = host_seq_pkg::cyc_reserved;
    endcase
  endfunction : decode_cycle

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      req_hold <= 2'h0;
    end else if (!req_s2) begin
      req_hold <= 2'h0;
    end else if (req_hold != 2'(host_seq_pkg::req_hold_cycles)) begin
      req_hold <= req_hold + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Code bus capture
  // ----------------------------------------------------------------
  assign code_new = display_code_bus != code_prev;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      code_prev <= 4'hF;
      shadow_pending <= 1'b0;
      shadow_from_line <= 1'b0;
      shadow_even <= 1'b0;
      field_is_odd <= 1'b1;
      xfer_pending <= 1'b0;
      xfer_sel <= 2'h0;
    end else begin
      code_prev <= display_code_bus;
      if (state == st_shadow && shadow_cnt == 2'h1)
        shadow_pending <= 1'b0;
      if (state == st_transfer)
        xfer_pending <= 1'b0;
      if (code_new) begin
        unique case (display_code_bus)
          host_seq_pkg::code_odd_field: begin
            shadow_pending <= 1'b1;
            shadow_from_line <= 1'b0;
            shadow_even <= 1'b0;
            field_is_odd <= 1'b1;
          end
          host_seq_pkg::code_even_field: begin
            shadow_pending <= 1'b1;
            shadow_from_line <= 1'b0;
            shadow_even <= 1'b1;
            field_is_odd <= 1'b0;
          end
          host_seq_pkg::code_display_line: begin
            shadow_pending <= 1'b1;
            shadow_from_line <= 1'b1;
          end
          host_seq_pkg::code_luma_xfer,
          host_seq_pkg::code_chroma_xfer,
          host_seq_pkg::code_dproc_xfer: begin
            xfer_pending <= 1'b1;
            xfer_sel <= display_code_bus[1:0];
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // T-state machine
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= st_idle;
      cyc <= host_seq_pkg::cyc_external;
      shadow_cnt <= 2'h0;
    end else begin
      unique case (state)
        st_idle: begin
          shadow_cnt <= 2'h0;
          if (xfer_pending) state <= st_transfer;
          else if (shadow_pending) state <= st_shadow;
          else if (req_hold == 2'(host_seq_pkg::req_hold_cycles)) begin
            cyc <= decode_cycle(reg_sel_s, mem_sel_s);
            state <= st_grant_deadband;
          end else if (refresh_pending || fifo_pending)
            state <= st_other;
        end
        st_grant_deadband:
          if (cyc == host_seq_pkg::cyc_external)
            state <= st_first_output;
          else
            state <= st_wait_addr_valid;
        st_wait_addr_valid:
          if (alen_s2)
            state <= (cyc == host_seq_pkg::cyc_memory) ?
                     st_mem_request : st_first_output;
        st_mem_request: state <= st_mem_wait;
        st_mem_wait: if (!memory_ready_n) state <= st_first_output;
        st_first_output: state <= st_wait_complete;
        st_wait_complete: if (!req_s2) state <= st_release;
        st_release: state <= st_idle;
        st_shadow: begin
          shadow_cnt <= shadow_cnt + 2'h1;
          if (shadow_cnt == 2'(host_seq_pkg::shadow_cycles - 1))
            state <= st_idle;
        end
        st_transfer: state <= st_idle;
        st_other: state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Host bus outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bus_grant_n <= 1'b1;
      host_ready_n <= 1'b1;
      bus_drive_en <= 1'b1;
      memory_request_n <= 1'b1;
      data_out <= 32'h00000000;
      write_enable_n_out <= 1'b1;
      byte_enable_n_out <= 4'hF;
      reg_write_data <= 16'h0000;
      reg_write_strobe <= 1'b0;
      refresh_grant <= 1'b0;
      fifo_grant <= 1'b0;
    end else begin
      reg_write_strobe <= 1'b0;
      refresh_grant <= 1'b0;
      fifo_grant <= 1'b0;
      memory_request_n <= !(state == st_wait_addr_valid && alen_s2 &&
                           cyc == host_seq_pkg::cyc_memory);
      unique case (state)
        st_idle: begin
          bus_drive_en <= !(req_hold == 2'(host_seq_pkg::req_hold_cycles)
                            && !xfer_pending && !shadow_pending);
          if (!xfer_pending && !shadow_pending &&
              req_hold != 2'(host_seq_pkg::req_hold_cycles)) begin
            refresh_grant <= refresh_pending;
            fifo_grant <= !refresh_pending && fifo_pending;
          end
        end
        st_grant_deadband: bus_grant_n <= 1'b0;
        st_first_output: begin
          host_ready_n <= cyc == host_seq_pkg::cyc_external ?
                          memory_ready_n : 1'b0;
          if (cyc == host_seq_pkg::cyc_register && !we_s)
            data_out <= {reg_read_data, reg_read_data};
        end
        st_wait_complete: if (!req_s2) begin
          host_ready_n <= 1'b1;
          bus_grant_n <= 1'b1;
          if (cyc == host_seq_pkg::cyc_register && we_s) begin
            reg_write_data <= be0_s ? data_in[15:0] : data_in[31:16];
            reg_write_strobe <= 1'b1;
          end
        end
        st_release: bus_drive_en <= 1'b1;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Working pointers and decoder pointer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      working <= '0;
    end else if (state == st_shadow && shadow_cnt == 2'h0) begin
      working.luma <= (shadow_from_line ? !field_is_odd : shadow_even) ?
                      shadow.luma_start_even : shadow.luma_start_odd;
      working.chroma <= shadow.chroma_start;
      working.display_proc <= shadow.display_proc_start;
    end else if (state == st_transfer) begin
      unique case (xfer_sel)
        2'h0: working.luma <= working.luma + shadow.luma_pitch;
        2'h1: working.chroma <= working.chroma + shadow.chroma_pitch;
        default:
          working.display_proc <= working.display_proc +
                                  shadow.display_proc_pitch;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) decoder_ptr <= host_seq_pkg::ptr_reset;
    else if (decoder_load) decoder_ptr <= decoder_load_value;
    else if (decoder_read) decoder_ptr <= decoder_ptr + 1'b1;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_shadow_two_cycles: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    $rose(state == st_shadow) |-> (state == st_shadow)[*2] ##1 state == st_idle)
    else $error("shadow copy not two cycles");
  chk_grant_after_deadband: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state == st_grant_deadband |=> !bus_grant_n && !bus_drive_en)
    else $error("grant missing after deadband");
  chk_entry_req_held: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    $rose(state == st_grant_deadband) |-> $past(req_s2, 2) && $past(req_s2))
    else $error("host state entered early");
  chk_wait_strobe: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state == st_wait_addr_valid && !alen_s2 |=> state == st_wait_addr_valid)
    else $error("left strobe wait early");
  chk_mem_req_pulse: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state == st_mem_request |-> !memory_request_n ##1 memory_request_n)
    else $error("memory request not one state");
  chk_ready_release: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state == st_release |-> host_ready_n && bus_grant_n ##1 bus_drive_en)
    else $error("release outputs wrong");
  chk_xfer_first: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state == st_idle && xfer_pending |=> state == st_transfer)
    else $error("transfer not highest priority");
  chk_ext_direct: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state == st_grant_deadband && cyc == host_seq_pkg::cyc_external
    |=> state == st_first_output)
    else $error("external cycle not direct");
  chk_decoder_up: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    decoder_read && !decoder_load |=> decoder_ptr == $past(decoder_ptr) + 1'b1)
    else $error("decoder pointer not incremented");

  cov_reg_cycle: cover property (@(posedge sys_clk) disable iff (!resetn)
    state == st_first_output && cyc == host_seq_pkg::cyc_register);
  cov_mem_cycle: cover property (@(posedge sys_clk) disable iff (!resetn)
    state == st_mem_wait ##1 state == st_first_output);
  cov_shadow: cover property (@(posedge sys_clk) disable iff (!resetn)
    state == st_shadow && shadow_from_line);

endmodule : host_bus_sequencer

/* host_seq_pkg.sv */
// Purpose: Shared types and constants for the host bus sequencer
// Assumes: Single 250 MHz clock domain
// Notes: Pointers are 30-bit double-word addresses
package host_seq_pkg;

  localparam int ptr_w = 30;
  localparam int code_w = 4;
  localparam int shadow_cycles = 2;
  localparam int req_hold_cycles = 2;
  localparam logic [ptr_w-1:0] ptr_reset = 30'h0000000;

  // Code bus values
  localparam logic [3:0] code_luma_xfer = 4'h0;
  localparam logic [3:0] code_chroma_xfer = 4'h1;
  localparam logic [3:0] code_dproc_xfer = 4'h2;
  localparam logic [3:0] code_display_line = 4'h8;
  localparam logic [3:0] code_odd_field = 4'hC;
  localparam logic [3:0] code_even_field = 4'hD;

  typedef enum logic [1:0] {
    cyc_external,
    cyc_register,
    cyc_memory,
    cyc_reserved
  } cycle_type_t;

  typedef struct packed {
    logic [ptr_w-1:0] luma_start_odd;
    logic [ptr_w-1:0] luma_start_even;
    logic [ptr_w-1:0] luma_pitch;
    logic [ptr_w-1:0] chroma_start;
    logic [ptr_w-1:0] chroma_pitch;
    logic [ptr_w-1:0] display_proc_start;
    logic [ptr_w-1:0] display_proc_pitch;
  } shadow_set_t;

  typedef struct packed {
    logic [ptr_w-1:0] luma;
    logic [ptr_w-1:0] chroma;
    logic [ptr_w-1:0] display_proc;
  } working_set_t;

endpackage : host_seq_pkg

/* host_mem_model.sv */
// Purpose: Memory side partner answering the sequencer's memory requests
// Assumes: Request and ready share sys_clk
// Notes: Answer latency set per cycle by the bench through delay
`timescale 1ns/10ps
module host_mem_model (
  // Clock
  input wire logic sys_clk,
  // Memory handshake
  input wire logic memory_request_n,
  input wire logic [3:0] delay,
  output logic memory_ready_n
);
  int cnt = 0;

  initial memory_ready_n = 1'b1;

  // -------------------------------------------------------------------
  // Ready pulse after the chosen latency
  // -------------------------------------------------------------------
  always @(negedge sys_clk) begin
    memory_ready_n <= 1'b1;
    if (cnt == 1) begin
      memory_ready_n <= 1'b0;
    end
    if (memory_request_n === 1'b0) begin
      cnt <= int'(delay) + 1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : host_mem_model

/* tb_host_bus_sequencer.sv */
// Purpose: Self-checking bench for the host bus sequencer
// Assumes: Inputs driven on the falling edge of sys_clk
// Notes: Host cycles, code bus actions, decoder pointer and priority
`timescale 1ns/10ps
module tb_host_bus_sequencer;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic host_request_n = 1'b1, reg_select_n = 1'b1, mem_select_n = 1'b1;
  logic addr_valid_strobe_n = 1'b1, write_enable_n_in = 1'b1;
  logic [3:0] byte_enable_n_in = 4'hF, display_code_bus = 4'hF, dly = 4'h0;
  logic [31:0] data_in = 32'h0, data_out, dq;
  logic [15:0] reg_read_data = 16'h0, reg_write_data, wq;
  logic refresh_pending = 1'b0, fifo_pending = 1'b0, decoder_load = 1'b0;
  logic decoder_read = 1'b0;
  logic [29:0] decoder_load_value = 30'h0, decoder_ptr;
  logic bus_grant_n, host_ready_n, write_enable_n_out, bus_drive_en;
  logic memory_request_n, memory_ready_n, reg_write_strobe, field_is_odd;
  logic refresh_grant, fifo_grant;
  logic [3:0] byte_enable_n_out;
  host_seq_pkg::shadow_set_t shadow = '0;
  host_seq_pkg::working_set_t working;
  int n, nreq = 0, errors = 0, checks_done = 0;

  host_bus_sequencer i_dut (.sys_clk, .resetn, .host_request_n,
    .reg_select_n, .mem_select_n, .addr_valid_strobe_n, .bus_grant_n,
    .host_ready_n, .write_enable_n_in, .byte_enable_n_in, .data_in,
    .data_out, .byte_enable_n_out, .write_enable_n_out, .bus_drive_en,
    .memory_request_n, .memory_ready_n, .reg_read_data, .reg_write_data,
    .reg_write_strobe, .display_code_bus, .refresh_pending, .fifo_pending,
    .refresh_grant, .fifo_grant, .decoder_load, .decoder_load_value,
    .decoder_read, .decoder_ptr, .shadow, .working, .field_is_odd);
  host_mem_model i_mem (.sys_clk, .memory_request_n, .delay(dly),
    .memory_ready_n);

  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (memory_request_n === 1'b0) nreq++;
  always @(posedge sys_clk) if (reg_write_strobe === 1'b1) wq <= reg_write_data;

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk

  function logic sig(input int k);
    case (k)
      0: sig = bus_grant_n;
      1: sig = host_ready_n;
      2: sig = refresh_grant;
      default: sig = fifo_grant;
    endcase
  endfunction : sig

  task wt(input int k, input logic v);
    n = 0;
    while (sig(k) !== v && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    if (sig(k) !== v) begin
      errors++;
      $display("ERROR %0t wait %0d got %0h exp %0h", $time, k, sig(k), v);
      end_sim();
    end
  endtask : wt

  // Whole host cycle; selects and direction held until grant drops
  task host(input logic rs, input logic ms, input logic we,
            input logic [3:0] be, input logic [31:0] d);
    int r;
    @(negedge sys_clk);
    reg_select_n = rs;
    mem_select_n = ms;
    write_enable_n_in = we;
    byte_enable_n_in = be;
    data_in = d;
    host_request_n = 1'b0;
    r = nreq;
    wt(0, 1'b0);
    chk(32'(n >= 3), 32'h1);
    chk(32'(bus_drive_en), 32'h0);
    addr_valid_strobe_n = 1'b0;
    if (!(rs && ms)) begin
      wt(1, 1'b0);
      dq = data_out;
    end else begin
      repeat (4) @(negedge sys_clk);
      chk(32'(host_ready_n), 32'h1);
    end
    chk(32'(nreq - r), 32'(!ms));
    host_request_n = 1'b1;
    wt(0, 1'b1);
    chk(32'(host_ready_n), 32'h1);
    @(negedge sys_clk);
    chk(32'(bus_drive_en), 32'h1);
    addr_valid_strobe_n = 1'b1;
    reg_select_n = 1'b1;
    mem_select_n = 1'b1;
    write_enable_n_in = 1'b1;
    byte_enable_n_in = 4'hF;
  endtask : host

  task code(input logic [3:0] c, input logic [29:0] e);
    @(negedge sys_clk);
    display_code_bus = c;
    repeat (3) @(negedge sys_clk);
    display_code_bus = 4'hF;
    repeat (4) @(negedge sys_clk);
    chk(32'(working.luma), 32'(e));
  endtask : code

  // -------------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    chk(32'({bus_grant_n, host_ready_n, bus_drive_en, field_is_odd}), 32'hF);
    chk(32'({write_enable_n_out, byte_enable_n_out}), 32'h1F);
    chk(32'(working.luma), 32'h0);
    reg_read_data = 16'hA5C3;
    host(1'b0, 1'b1, 1'b1, 4'hC, 32'h0);
    chk(dq, 32'hA5C3A5C3);
    host(1'b0, 1'b1, 1'b0, 4'hC, 32'h12345678);
    chk(32'(wq), 32'h5678);
    host(1'b0, 1'b1, 1'b0, 4'h3, 32'h12345678);
    chk(32'(wq), 32'h1234);
    $display("test register cycles done");
    dly = 4'h3;
    host(1'b1, 1'b0, 1'b0, 4'hE, 32'h0);
    dly = 4'h0;
    host(1'b1, 1'b0, 1'b1, 4'h0, 32'h0);
    host(1'b1, 1'b1, 1'b1, 4'hF, 32'h0);
    $display("test memory and external cycles done");
    shadow.luma_start_odd = 30'h100;
    shadow.luma_start_even = 30'h200;
    shadow.luma_pitch = 30'h10;
    shadow.chroma_start = 30'h300;
    shadow.chroma_pitch = 30'h20;
    shadow.display_proc_start = 30'h400;
    code(4'hC, 30'h100);
    chk(32'(working.chroma), 32'h300);
    chk(32'(working.display_proc), 32'h400);
    chk(32'(field_is_odd), 32'h1);
    code(4'h0, 30'h110);
    code(4'h8, 30'h100);
    code(4'hD, 30'h200);
    chk(32'(field_is_odd), 32'h0);
    code(4'h1, 30'h200);
    chk(32'(working.chroma), 32'h320);
    code(4'h0, 30'h210);
    code(4'h8, 30'h200);
    $display("test shadow copy done");
    @(negedge sys_clk);
    decoder_load = 1'b1;
    decoder_load_value = 30'h40;
    @(negedge sys_clk);
    decoder_load = 1'b0;
    decoder_read = 1'b1;
    repeat (3) @(negedge sys_clk);
    decoder_read = 1'b0;
    @(negedge sys_clk);
    chk(32'(decoder_ptr), 32'h43);
    refresh_pending = 1'b1;
    fifo_pending = 1'b1;
    wt(2, 1'b1);
    chk(32'(fifo_grant), 32'h0);
    refresh_pending = 1'b0;
    wt(3, 1'b1);
    fifo_pending = 1'b0;
    $display("test decoder and priority done");
    end_sim();
  end
endmodule : tb_host_bus_sequencer
